/* File: core/cfsh_pkg.sv */
package cfsh_pkg;
  // ----------------------------------------
  // Widths and serial frame
  // ----------------------------------------
  localparam int DW = 10;
  localparam int AW = 5;
  localparam int NREG = 5;
  localparam int NINR = 3;
  localparam int HDR_BITS = 6;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] HDR_LAST = 5'h05;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  // ----------------------------------------
  // Register map (index order: inrush a, b, c, config, enable)
  // ----------------------------------------
  localparam logic [AW-1:0] ADR_FLAGS = 5'h02;
  localparam logic [AW-1:0] ADR_WEN = 5'h0c;
  localparam logic [AW-1:0] ADR_ALERT_EN = 5'h0d;
  localparam logic [AW-1:0] PRI_ADR [NREG] = '{5'h05, 5'h06, 5'h07, 5'h09, 5'h0a};
  localparam logic [AW-1:0] SHD_ADR [NREG] = '{5'h16, 5'h17, 5'h18, 5'h19, 5'h1a};
  // ----------------------------------------
  // Reset and fixed values
  // ----------------------------------------
  localparam logic [DW-1:0] PRI_RST [NREG] = '{10'h0c0, 10'h180, 10'h1d8, 10'h183, 10'h000};
  localparam logic [DW-1:0] SHD_RST [NREG] = '{10'h33f, 10'h27f, 10'h227, 10'h27c, 10'h3ff};
  localparam logic [DW-1:0] SHD_FIX [NINR] = '{10'h0c0, 10'h180, 10'h1d8};
  localparam logic [DW-1:0] WEN_KEY = 10'h294;
  localparam logic [DW-1:0] ZERO_W = 10'h000;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FLAG_BIT = 0;
  localparam int ALERT_BIT = 4;
  localparam int FAST_BIT = 1;
  localparam int CFG_IDX = 3;
  localparam int SINK_IDX = 4;
endpackage

/* File: core/cfsh_serial_port.sv */
`timescale 1ns/10ps
module cfsh_serial_port import cfsh_pkg::*; (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic mosi_i,
  input wire logic [DW-1:0] rdata_i,
  output logic miso_o,
  output logic [AW-1:0] addr_o,
  output logic [DW-1:0] wdata_o,
  output logic wr_stb_o,
  output logic rd_stb_o
);
  typedef enum logic [1:0] {SP_IDLE, SP_HDR, SP_DATA, SP_DONE} cfsh_sp_t;
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Third stage holds the last settled sample, so an edge counts where stages 2 and 3 differ
  logic [2:0] sclk_r, csn_r, mosi_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sclk_r <= 3'h0;
      csn_r <= 3'h7;
      mosi_r <= 3'h0;
    end else if (ce_i) begin
      sclk_r <= {sclk_r[1:0], sclk_i};
      csn_r <= {csn_r[1:0], csn_i};
      mosi_r <= {mosi_r[1:0], mosi_i};
    end
  end
  logic rise, fall, sel;
  assign rise = sclk_r[1] & ~sclk_r[2];
  assign fall = ~sclk_r[1] & sclk_r[2];
  assign sel = ~csn_r[2];
  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  cfsh_sp_t st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [FRAME_BITS-1:0] rx_r, rx_nxt;
  logic [DW-1:0] tx_r, tx_nxt, wdata_nxt;
  logic [AW-1:0] addr_nxt;
  logic wr_r, wr_nxt, miso_nxt, wr_stb_nxt, rd_stb_nxt;
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    addr_nxt = addr_o;
    wdata_nxt = wdata_o;
    wr_nxt = wr_r;
    miso_nxt = miso_o;
    wr_stb_nxt = 1'b0;
    rd_stb_nxt = 1'b0;
    if (rd_stb_o) begin
      tx_nxt = rdata_i;
    end
    if (fall && st_r == SP_DATA) begin
      miso_nxt = tx_r[DW-1];
      tx_nxt = {tx_r[DW-2:0], 1'b0};
    end
    if (!sel) begin
      st_nxt = SP_IDLE;
      cnt_nxt = CNT_ZERO;
    end else begin
      unique case (st_r)
        SP_IDLE: begin
          st_nxt = SP_HDR;
          cnt_nxt = CNT_ZERO;
        end
        SP_HDR: begin
          if (rise) begin
            rx_nxt = {rx_r[FRAME_BITS-2:0], mosi_r[2]};
            cnt_nxt = cnt_r + CNT_ONE;
            if (cnt_r == HDR_LAST) begin
              addr_nxt = rx_r[AW-1:0];
              wr_nxt = mosi_r[2];
              rd_stb_nxt = ~mosi_r[2];
              st_nxt = SP_DATA;
            end
          end
        end
        SP_DATA: begin
          if (rise) begin
            rx_nxt = {rx_r[FRAME_BITS-2:0], mosi_r[2]};
            cnt_nxt = cnt_r + CNT_ONE;
            if (cnt_r == FRAME_LAST) begin
              wdata_nxt = {rx_r[DW-2:0], mosi_r[2]};
              wr_stb_nxt = wr_r;
              st_nxt = SP_DONE;
            end
          end
        end
        SP_DONE: st_nxt = SP_DONE;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= SP_IDLE;
      cnt_r <= CNT_ZERO;
      rx_r <= 16'h0000;
      tx_r <= 10'h000;
      addr_o <= 5'h00;
      wdata_o <= 10'h000;
      wr_r <= 1'b0;
      miso_o <= 1'b0;
      wr_stb_o <= 1'b0;
      rd_stb_o <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      addr_o <= addr_nxt;
      wdata_o <= wdata_nxt;
      wr_r <= wr_nxt;
      miso_o <= miso_nxt;
      wr_stb_o <= wr_stb_nxt;
      rd_stb_o <= rd_stb_nxt;
    end
  end
endmodule

/* File: core/cfsh_top.sv */
`timescale 1ns/10ps
// Summary of operation
// (RULE_01) Every shadow register is compared bitwise with its primary; difference sets flag.
// (RULE_02) Flag set and alert enabled drives the active-low fault output.
// (RULE_03) Shadows reset to the inverse of primary reset, except reduced-variant inrush shadows; config 0x27c, enable 0x3ff.
// (RULE_04) Full variant: inrush shadows reset to 0x33f, 0x27f, 0x227, read/write.
// (RULE_05) Reduced variant: inrush shadows read-only, fixed at 0x0c0, 0x180, 0x1d8.
// (RULE_06) Reduced variant: writes to the three inrush primaries are always ignored.
// (RULE_07) Reduced variant: quick inrush mode only, no converter-triggered inrush.
// (RULE_08) Reduced variant: no limit on the number of inrush pulses.
// (RULE_09) Reduced variant: inrush shadows raise no mismatch unless contents corrupt.
// (RULE_10) Fault output can be enabled to act as an interrupt to the host.
// (RULE_11) Host writes 0x294 to write-enable before configuring, restores 0x000 after.
// (RULE_12) Comparison runs every cycle; flag sets no later than next cycle.
module cfsh_top import cfsh_pkg::*; #(
  parameter bit REDUCED = 1'b0
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic csn_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic fault_o,
  output logic fault_oe_o,
  output logic fast_mode_o,
  output logic pulse_limit_o
);
  // ----------------------------------------
  // Serial access
  // ----------------------------------------
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic wr_stb, rd_stb;
  cfsh_serial_port u_port (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .sclk_i(sclk_i),
    .csn_i(csn_i),
    .mosi_i(mosi_i),
    .rdata_i(rdata),
    .miso_o(miso_o),
    .addr_o(addr),
    .wdata_o(wdata),
    .wr_stb_o(wr_stb),
    .rd_stb_o(rd_stb)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic locked(input int i);
    return REDUCED && (i < NINR);
  endfunction
  function automatic logic [DW-1:0] shd_reset(input int i);
    return locked(i) ? SHD_FIX[i] : SHD_RST[i];
  endfunction
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [DW-1:0] pri_r [NREG];
  logic [DW-1:0] pri_nxt [NREG];
  logic [DW-1:0] shd_r [NREG];
  logic [DW-1:0] shd_nxt [NREG];
  logic [DW-1:0] wen_r, wen_nxt, alert_r, alert_nxt;
  logic flag_r, flag_nxt, mismatch, wr_ok;
  logic fault_oe_nxt, fast_nxt;
  always_comb begin
    mismatch = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      mismatch = mismatch | (|(pri_r[i] ^ shd_r[i])); // see RULE_01 see RULE_09
    end
  end
  always_comb begin
    pri_nxt = pri_r;
    shd_nxt = shd_r;
    wen_nxt = wen_r;
    alert_nxt = alert_r;
    flag_nxt = flag_r;
    // Key check keeps a noisy serial line from corrupting settings
    wr_ok = (wen_r == WEN_KEY); // see RULE_11
    if (wr_stb) begin
      if (addr == ADR_WEN) begin
        wen_nxt = wdata;
      end else if (wr_ok) begin
        if (addr == ADR_ALERT_EN) begin
          alert_nxt = wdata; // see RULE_10
        end
        for (int i = 0; i < NREG; i++) begin
          if (addr == PRI_ADR[i] && !locked(i)) begin
            pri_nxt[i] = wdata; // see RULE_06
          end
          if (addr == SHD_ADR[i] && !locked(i)) begin
            shd_nxt[i] = wdata; // see RULE_04 see RULE_05
          end
        end
      end
    end
    // Read of the flag word clears it; a coinciding mismatch still wins
    if (rd_stb && addr == ADR_FLAGS) begin
      flag_nxt = 1'b0;
    end
    if (mismatch) begin
      flag_nxt = 1'b1; // see RULE_01 see RULE_12
    end
  end
  always_comb begin
    fault_oe_nxt = flag_r & alert_r[ALERT_BIT]; // see RULE_02 see RULE_10
    // Reduced part has no converter trigger path at all
    fast_nxt = REDUCED ? 1'b1 : pri_r[CFG_IDX][FAST_BIT]; // see RULE_07
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NREG; i++) begin
        pri_r[i] <= PRI_RST[i];
        shd_r[i] <= shd_reset(i); // see RULE_03 see RULE_04 see RULE_05
      end
      wen_r <= ZERO_W;
      alert_r <= ZERO_W;
      flag_r <= 1'b0;
      fault_oe_o <= 1'b0;
      fault_o <= 1'b0;
      fast_mode_o <= REDUCED;
      pulse_limit_o <= ~REDUCED;
    end else if (ce_i) begin
      pri_r <= pri_nxt;
      shd_r <= shd_nxt;
      wen_r <= wen_nxt;
      alert_r <= alert_nxt;
      flag_r <= flag_nxt;
      fault_oe_o <= fault_oe_nxt;
      // Open drain: level is always low, only the enable moves
      fault_o <= 1'b0;
      fast_mode_o <= fast_nxt;
      pulse_limit_o <= ~REDUCED; // see RULE_08
    end
  end
  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdata = ZERO_W;
    if (addr == ADR_FLAGS) begin
      rdata[FLAG_BIT] = flag_r;
    end
    if (addr == ADR_WEN) begin
      rdata = wen_r;
    end
    if (addr == ADR_ALERT_EN) begin
      rdata = alert_r;
    end
    for (int i = 0; i < NREG; i++) begin
      if (addr == PRI_ADR[i]) begin
        rdata = pri_r[i];
      end
      if (addr == SHD_ADR[i]) begin
        rdata = shd_r[i];
      end
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  mismatch_flag_a: assert property (ce_i && mismatch |=> flag_r) // see RULE_01
    else $error("mismatch did not set flag");
  flag_next_a: assert property (ce_i && !flag_r && mismatch |=> // see RULE_12
    flag_r && $changed(flag_r))
    else $error("flag late after mismatch");
  fault_drive_a: assert property (ce_i && flag_r && alert_r[ALERT_BIT] |=> // see RULE_02
    fault_oe_o && !fault_o)
    else $error("fault not asserted");
  fault_quiet_a: assert property (ce_i && !(flag_r && alert_r[ALERT_BIT]) |=> // see RULE_10
    !fault_oe_o)
    else $error("fault asserted without enable");
  reset_shadow_a: assert property ($past(srst_i) |-> // see RULE_03
    shd_r[CFG_IDX] == 10'h27c && shd_r[SINK_IDX] == 10'h3ff &&
    shd_r[CFG_IDX] == ~pri_r[CFG_IDX])
    else $error("shadow reset value wrong");
  full_inrush_a: assert property (!REDUCED && $past(srst_i) |-> // see RULE_04
    shd_r[0] == 10'h33f && shd_r[1] == 10'h27f && shd_r[2] == 10'h227)
    else $error("inrush shadow reset wrong");
  fixed_shadow_a: assert property (REDUCED |-> // see RULE_05
    shd_r[0] == 10'h0c0 && shd_r[1] == 10'h180 && shd_r[2] == 10'h1d8)
    else $error("reduced shadow changed");
  locked_primary_a: assert property (REDUCED && wr_stb |=> // see RULE_06
    $stable(pri_r[0]) && $stable(pri_r[1]) && $stable(pri_r[2]))
    else $error("locked primary written");
  fast_only_a: assert property (REDUCED |-> fast_mode_o) // see RULE_07
    else $error("reduced part left quick mode");
  no_limit_a: assert property (REDUCED |-> !pulse_limit_o) // see RULE_08
    else $error("reduced part limits pulses");
  quiet_inrush_a: assert property (REDUCED |-> // see RULE_09
    pri_r[0] == shd_r[0] && pri_r[1] == shd_r[1] && pri_r[2] == shd_r[2])
    else $error("reduced inrush mismatch");
  write_gate_a: assert property (ce_i && wr_stb && wen_r != WEN_KEY && // see RULE_11
    addr != ADR_WEN |=> $stable(pri_r[CFG_IDX]) && $stable(shd_r[CFG_IDX]))
    else $error("write accepted without key");
  // ----------------------------------------
  // Write, flag, mode and freeze checks
  // ----------------------------------------
  shadow_write_a: assert property (ce_i && wr_stb && wr_ok && // see RULE_04
    !REDUCED && addr == SHD_ADR[0] |=> shd_r[0] == $past(wdata))
    else $error("inrush shadow write lost");
  // Sticky flag: a short glitch must still be seen by the next flag read
  flag_hold_a: assert property (ce_i && flag_r && // see RULE_01
    !(rd_stb && addr == ADR_FLAGS) |=> flag_r)
    else $error("flag dropped without a read");
  flag_clear_a: assert property (ce_i && rd_stb && // see RULE_01
    addr == ADR_FLAGS && !mismatch |=> !flag_r)
    else $error("flag read did not clear");
  fast_follow_a: assert property (!REDUCED && ce_i |=> // see RULE_07
    fast_mode_o == $past(pri_r[CFG_IDX][FAST_BIT]))
    else $error("quick mode does not follow config");
  full_limit_a: assert property (!REDUCED |-> pulse_limit_o) // see RULE_08
    else $error("full part lost pulse limit");
  alert_write_a: assert property (ce_i && wr_stb && wr_ok && // see RULE_10
    addr == ADR_ALERT_EN |=> alert_r == $past(wdata))
    else $error("alert enable write lost");
  ce_freeze_a: assert property (!ce_i |=>
    $stable(flag_r) && $stable(shd_r[CFG_IDX]) && $stable(fault_oe_o))
    else $error("state moved while clock enable low");
  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  keyed_write_c: cover property (ce_i && wr_stb && wen_r == WEN_KEY);
  flag_clear_c: cover property (ce_i && rd_stb && addr == ADR_FLAGS && !mismatch);
  freeze_c: cover property (!ce_i && flag_r);
  fault_on_c: cover property (fault_oe_o);
  flag_read_c: cover property (rd_stb && addr == ADR_FLAGS && flag_r);
endmodule

/* File: verif/cfsh_host_model.sv */
`timescale 1ns/10ps
module cfsh_host_model import cfsh_pkg::*; (
  input wire logic clk_i,
  input wire logic miso_full_i,
  input wire logic miso_red_i,
  output logic sclk_o,
  output logic [1:0] csn_n_o,
  output logic mosi_o
);
  // ----------------------------------------
  // Serial host, mode 0, one access a frame
  // ----------------------------------------
  initial begin
    sclk_o = 1'b0;
    csn_n_o = 2'h3;
    mosi_o = 1'b0;
  end
  // Half periods of 8 clocks leave room for the 3-stage pin synchronisers
  task automatic xfer(input logic dev, input logic [AW-1:0] adr, input logic wr,
                      input logic [DW-1:0] wd, output logic [DW-1:0] rd);
    logic [15:0] frm;
    frm = {adr, wr, wd};
    rd = ZERO_W;
    @(posedge clk_i);
    csn_n_o[dev] <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 15; i >= 0; i--) begin
      mosi_o <= frm[i];
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'b1;
      if (i < DW) rd = {rd[DW-2:0], dev ? miso_red_i : miso_full_i};
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    csn_n_o[dev] <= 1'b1;
    // Released data line shows the inverse, never a stale copy
    mosi_o <= ~mosi_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/10ps
module testbench import cfsh_pkg::*;;
  // ----------------------------------------
  // Two variants on one host
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce = 1'b1;
  logic sclk, mosi, miso_f, miso_r, flt_f, oe_f, fast_r, lim_f, lim_r;
  logic fast_f, flt_r, oe_r;
  logic [1:0] csn_n;
  logic [DW-1:0] rd;
  wire alert_f = oe_f ? flt_f : 1'b1;
  int mismatches = 0;
  int check_count = 0;
  initial forever #2.5 clk_i = ~clk_i;
  cfsh_host_model host_u (.clk_i(clk_i), .miso_full_i(miso_f), .miso_red_i(miso_r),
    .sclk_o(sclk), .csn_n_o(csn_n), .mosi_o(mosi));
  cfsh_top #(.REDUCED(1'b0)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce),
    .sclk_i(sclk), .csn_i(csn_n[0]), .mosi_i(mosi), .miso_o(miso_f), .fault_o(flt_f),
    .fault_oe_o(oe_f), .fast_mode_o(fast_f), .pulse_limit_o(lim_f));
  cfsh_top #(.REDUCED(1'b1)) dut_r_u (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce),
    .sclk_i(sclk), .csn_i(csn_n[1]), .mosi_i(mosi), .miso_o(miso_r), .fault_o(flt_r),
    .fault_oe_o(oe_r), .fast_mode_o(fast_r), .pulse_limit_o(lim_r));
  task automatic check_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t bit %b exp %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic d, input logic [AW-1:0] a, input logic [DW-1:0] v);
    host_u.xfer(d, a, 1'b1, v, rd);
  endtask
  task automatic rd_chk(input logic d, input logic [AW-1:0] a, input logic [DW-1:0] e);
    host_u.xfer(d, a, 1'b0, ZERO_W, rd);
    check_word(rd, e);
  endtask
  task automatic t_reset();
    for (int i = 0; i < NREG; i++) begin
      rd_chk(1'b0, SHD_ADR[i], SHD_RST[i]);
      rd_chk(1'b1, SHD_ADR[i], i < NINR ? SHD_FIX[i] : SHD_RST[i]);
    end
    check_bit(fast_r, 1'b1);
    check_bit(fast_f, 1'b1);
    check_bit(lim_r, 1'b0);
    check_bit(lim_f, 1'b1);
    host_u.xfer(1'b0, ADR_FLAGS, 1'b0, ZERO_W, rd);
    check_bit(rd[FLAG_BIT], 1'b1);
    $display("test reset done");
  endtask
  task automatic t_fault();
    wr(1'b0, ADR_WEN, WEN_KEY);
    wr(1'b0, ADR_ALERT_EN, ZERO_W);
    check_bit(oe_f, 1'b0);
    wr(1'b0, ADR_ALERT_EN, 10'h010);
    check_bit(alert_f, 1'b0);
    for (int i = 0; i < NREG; i++) wr(1'b0, SHD_ADR[i], PRI_RST[i]);
    host_u.xfer(1'b0, ADR_FLAGS, 1'b0, ZERO_W, rd);
    host_u.xfer(1'b0, ADR_FLAGS, 1'b0, ZERO_W, rd);
    check_bit(rd[FLAG_BIT], 1'b0);
    check_bit(alert_f, 1'b1);
    // Single bit off at the top of the word
    wr(1'b0, SHD_ADR[CFG_IDX], PRI_RST[CFG_IDX] ^ 10'h200);
    check_bit(oe_f, 1'b1);
    // Full part follows the quick-mode bit of the config primary
    wr(1'b0, PRI_ADR[CFG_IDX], PRI_RST[CFG_IDX] ^ 10'h002);
    check_bit(fast_f, 1'b0);
    $display("test fault done");
  endtask
  task automatic t_lock();
    wr(1'b0, ADR_WEN, ZERO_W);
    wr(1'b0, SHD_ADR[SINK_IDX], 10'h155);
    rd_chk(1'b0, SHD_ADR[SINK_IDX], PRI_RST[SINK_IDX]);
    rd_chk(1'b0, 5'h1f, ZERO_W);
    wr(1'b1, ADR_WEN, WEN_KEY);
    for (int i = 0; i < NINR; i++) begin
      wr(1'b1, PRI_ADR[i], ~SHD_FIX[i]);
      wr(1'b1, SHD_ADR[i], ~SHD_FIX[i]);
      rd_chk(1'b1, PRI_ADR[i], SHD_FIX[i]);
      rd_chk(1'b1, SHD_ADR[i], SHD_FIX[i]);
    end
    wr(1'b1, SHD_ADR[CFG_IDX], PRI_RST[CFG_IDX]);
    wr(1'b1, SHD_ADR[SINK_IDX], PRI_RST[SINK_IDX]);
    host_u.xfer(1'b1, ADR_FLAGS, 1'b0, ZERO_W, rd);
    host_u.xfer(1'b1, ADR_FLAGS, 1'b0, ZERO_W, rd);
    check_bit(rd[FLAG_BIT], 1'b0);
    wr(1'b1, PRI_ADR[CFG_IDX], 10'h181);
    check_bit(fast_r, 1'b1);
    wr(1'b1, ADR_ALERT_EN, 10'h010);
    check_bit(oe_r, 1'b1);
    check_bit(flt_r, 1'b0);
    $display("test lock done");
  endtask
  task automatic t_freeze();
    // Key frame sent while frozen must be lost, so the next write is refused
    ce <= 1'b0;
    wr(1'b0, ADR_WEN, WEN_KEY);
    check_bit(oe_f, 1'b1);
    ce <= 1'b1;
    wr(1'b0, SHD_ADR[SINK_IDX], 10'h155);
    rd_chk(1'b0, SHD_ADR[SINK_IDX], PRI_RST[SINK_IDX]);
    $display("test freeze done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_fault();
    t_lock();
    t_freeze();
    report_and_stop();
  end
  // About 50 frames of 281 clocks, some 14k clocks; 50k clocks is a safe limit
  initial begin
    #250000;
    mismatches++;
    report_and_stop();
  end
endmodule
